// *** src/adc_pkg.sv ***
`default_nettype none
package adc_pkg;
  localparam int unsigned CH_COUNT = 8;
  localparam logic [2:0] LAST_CHANNEL = 3'h7;
  localparam logic [2:0] GUARD_LO_CHANNEL = 3'h6;
  // 84 sampling cycles out of a 138-cycle conversion
  localparam logic [7:0] SAMPLE_CYCLES = 8'h54;
  localparam logic [7:0] TOTAL_CYCLES = 8'h8A;
  localparam logic [7:0] CONVERT_CYCLES = TOTAL_CYCLES - SAMPLE_CYCLES - 8'h01;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_CMP = 8'h0C;
  localparam logic [7:0] ADR_LT6 = 8'h10;
  localparam logic [7:0] ADR_UT6 = 8'h14;
  localparam logic [7:0] ADR_LT7 = 8'h18;
  localparam logic [7:0] ADR_UT7 = 8'h1C;
  localparam logic [7:0] ADR_VECTOR = 8'h40;
  localparam logic [2:0] ADR_DATA_HI = 3'h1;

  typedef struct packed {
    logic [2:0] irqLevel;
    logic intTrigEn;
    logic extTrigEn;
    logic powerOn;
    logic [2:0] startChannel;
    logic cont;
    logic conversionRun;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 11'h000;
  localparam logic [7:0] UPPER_RESET = 8'hFF;
  localparam logic [7:0] LOWER_RESET = 8'h00;
  localparam logic [3:0] CMP_LOW_ONES = 4'hF;

  // status and mask layout
  localparam int unsigned IRQ_EOC = 0;
  localparam int unsigned IRQ_WDOG = 1;

  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_WDOG = 2'h1;
  localparam logic [1:0] VEC_EOC = 2'h2;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } window_t;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SAMPLE = 2'b01,
    CONVERT = 2'b11,
    STORE = 2'b10
  } seq_state_t;
endpackage
`default_nettype wire

// *** src/adc_result_mem.sv ***
`default_nettype none
module adc_result_mem
  import adc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstSyncB,
  input wire logic wrEn,
  input wire logic [2:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [2:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] entry_q [CH_COUNT];
  logic [7:0] rdData_q;

  // each entry keeps only the latest value written to it
  for (genvar i = 0; i < CH_COUNT; i++) begin : g_entry
    always_ff @(posedge clk_sys or negedge rstSyncB) begin
      if (!rstSyncB) begin
        entry_q[i] <= 8'h00;
      end else if (wrEn && wrAddr == 3'(i)) begin
        entry_q[i] <= wrData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= entry_q[rdAddr];
    end
  end

  assign rdData = rdData_q;
endmodule
`default_nettype wire

// *** src/adc_autoscan_sequencer.sv ***
// Behaviour
// - 138 cycles per conversion, 84 sampling
// - results are 8-bit, reference-scaled
// - eight inputs, converted in sequence
// - cont bit selects continuous or single
// - start channel, increment up to 7
// - run bit starts scan to 7
// - single: clear run, raise end event
// - continuous: restart at start channel
// - end event after every channel 7
// - new result overwrites channel data
// - two window comparators flag and interrupt
// - two maskable requests, fixed order, level
// - external or timer trigger starts scan
// - power-on bit clear idles the converter
// - triggers ignored while run bit set
// - in range: below upper, at/above lower
// - watchdog request served before end event
`default_nettype none
module adc_autoscan_sequencer
  import adc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic extTrigger,
  input wire logic timerTrigger,
  input wire logic [7:0] convResult,
  output logic [2:0] muxChannel,
  output logic sampleHold,
  output logic convActive,
  output logic powerDown,
  output logic irq,
  output logic [2:0] irqLevel
);
  logic rstMeta_q;
  logic rstSyncB;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncB <= rstMeta_q;
    end
  end

  // bus slave: ack two cycles after the request appears
  logic busReq;
  logic stage_q;
  logic ack_q;
  logic [31:0] datOut_q;
  logic wrStrobe;
  logic [31:0] readMux;

  assign busReq = wb_cyc_i & wb_stb_i;
  assign wrStrobe = busReq & wb_we_i & ack_q;

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      stage_q <= 1'b0;
      ack_q <= 1'b0;
      datOut_q <= 32'h0000_0000;
    end else begin
      stage_q <= busReq & ~stage_q & ~ack_q;
      ack_q <= stage_q;
      if (stage_q) begin
        datOut_q <= readMux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = datOut_q;

  wire hitCtrl = wb_adr_i == ADR_CTRL;
  wire hitStatus = wb_adr_i == ADR_STATUS;
  wire hitMask = wb_adr_i == ADR_MASK;
  wire hitCmp = wb_adr_i == ADR_CMP;
  wire hitVector = wb_adr_i == ADR_VECTOR;
  wire hitData = wb_adr_i[7:5] == ADR_DATA_HI && wb_adr_i[1:0] == 2'h0;
  wire [2:0] dataIdx = wb_adr_i[4:2];
  wire lane0 = wb_sel_i[0];
  wire lane1 = wb_sel_i[1];

  ctrl_t ctrl_q;
  ctrl_t ctrl_d;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [3:0] cmpFlags_q;
  window_t win_q [2];
  seq_state_t state_q;
  seq_state_t state_d;
  logic [7:0] cycleCnt_q;
  logic [2:0] channel_q;
  logic extPrev_q;
  logic timerPrev_q;
  logic [7:0] memRd;

  // conversion sequencing
  wire phaseDone = cycleCnt_q == 8'h00;
  wire storing = state_q == STORE;
  wire lastChannel = channel_q == LAST_CHANNEL;
  wire scanDone = storing & lastChannel;
  wire [7:0] sample = convResult;

  wire extEdge = ctrl_q.extTrigEn & extTrigger & ~extPrev_q;
  wire timerEdge = ctrl_q.intTrigEn & timerTrigger & ~timerPrev_q;
  // a trigger only starts a scan from rest; once running, continuous mode ignores the rest
  wire trigStart = (extEdge | timerEdge) & ~ctrl_q.conversionRun;

  always_comb begin
    ctrl_d = ctrl_q;
    if (trigStart) begin
      ctrl_d.conversionRun = 1'b1;
    end
    if (scanDone && !ctrl_q.cont) begin
      ctrl_d.conversionRun = 1'b0;
    end
    if (wrStrobe && hitCtrl && lane0) begin
      ctrl_d[7:0] = wb_dat_i[7:0];
    end
    if (wrStrobe && hitCtrl && lane1) begin
      ctrl_d[10:8] = wb_dat_i[10:8];
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      ctrl_q <= CTRL_RESET;
      extPrev_q <= 1'b0;
      timerPrev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      extPrev_q <= extTrigger;
      timerPrev_q <= timerTrigger;
    end
  end

  // powered down or run cleared: abandon the scan at once
  wire goAhead = ctrl_q.conversionRun & ctrl_q.powerOn;

  always_comb begin
    state_d = state_q;
    if (!goAhead) begin
      state_d = IDLE;
    end else begin
      case (state_q)
        IDLE: state_d = SAMPLE;
        SAMPLE: state_d = phaseDone ? CONVERT : SAMPLE;
        CONVERT: state_d = phaseDone ? STORE : CONVERT;
        STORE: state_d = (lastChannel && !ctrl_q.cont) ? IDLE : SAMPLE;
        default: state_d = IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      state_q <= IDLE;
      cycleCnt_q <= 8'h00;
      channel_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (state_d == SAMPLE && state_q != SAMPLE) begin
        cycleCnt_q <= SAMPLE_CYCLES - 8'h01;
      end else if (state_d == CONVERT && state_q == SAMPLE) begin
        cycleCnt_q <= CONVERT_CYCLES - 8'h01;
      end else if (!phaseDone) begin
        cycleCnt_q <= cycleCnt_q - 8'h01;
      end
      if (state_q == IDLE) begin
        channel_q <= ctrl_q.startChannel;
      end else if (storing) begin
        channel_q <= lastChannel ? ctrl_q.startChannel : channel_q + 3'h1;
      end
    end
  end

  assign muxChannel = channel_q;
  assign sampleHold = state_q == SAMPLE;
  assign convActive = state_q != IDLE;
  assign powerDown = ~ctrl_q.powerOn;
  assign irqLevel = ctrl_q.irqLevel;

  // result store; conversion wins a same-cycle software write
  wire swDataWr = wrStrobe & hitData & lane0;
  wire memWr = storing | swDataWr;
  wire [2:0] memWrAddr = storing ? channel_q : dataIdx;
  wire [7:0] memWrData = storing ? sample : wb_dat_i[7:0];

  adc_result_mem u_mem (
    .clk_sys(clk_sys),
    .rstSyncB(rstSyncB),
    .wrEn(memWr),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(dataIdx),
    .rdData(memRd)
  );

  // window comparators on channels 6 and 7
  logic [3:0] outOfRange;
  for (genvar g = 0; g < 2; g++) begin : g_window
    wire guarded = storing && channel_q == GUARD_LO_CHANNEL + 3'(g);
    assign outOfRange[2*g] = guarded && sample < win_q[g].lower;
    assign outOfRange[2*g+1] = guarded && sample >= win_q[g].upper;
    always_ff @(posedge clk_sys or negedge rstSyncB) begin
      if (!rstSyncB) begin
        win_q[g] <= {UPPER_RESET, LOWER_RESET};
      end else if (wrStrobe && lane0) begin
        if (wb_adr_i == (g == 0 ? ADR_LT6 : ADR_LT7)) begin
          win_q[g].lower <= wb_dat_i[7:0];
        end
        if (wb_adr_i == (g == 0 ? ADR_UT6 : ADR_UT7)) begin
          win_q[g].upper <= wb_dat_i[7:0];
        end
      end
    end
  end

  // sticky events: a set in the clearing cycle survives
  logic [1:0] eventSet;
  logic [1:0] eventClr;
  assign eventSet[IRQ_EOC] = scanDone;
  assign eventSet[IRQ_WDOG] = |outOfRange;
  assign eventClr = (wrStrobe && hitStatus && lane0) ? wb_dat_i[1:0] : 2'h0;
  // comparator flags follow the watchdog bit down once it is really cleared
  wire cmpClr = eventClr[IRQ_WDOG] & ~eventSet[IRQ_WDOG];

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      status_q <= 2'h0;
      mask_q <= 2'h0;
      cmpFlags_q <= 4'h0;
    end else begin
      status_q <= (status_q & ~eventClr) | eventSet;
      if (wrStrobe && hitMask && lane0) begin
        mask_q <= wb_dat_i[1:0];
      end
      cmpFlags_q <= (cmpClr ? 4'h0 : cmpFlags_q) | outOfRange;
    end
  end

  wire [1:0] pending = status_q & mask_q;
  assign irq = |pending;

  // fixed order: watchdog first, end event stays pending behind it
  wire [1:0] vector = pending[IRQ_WDOG] ? VEC_WDOG :
                      pending[IRQ_EOC] ? VEC_EOC : VEC_NONE;

  assign readMux = hitCtrl ? {21'h00_0000, ctrl_q} :
                   hitStatus ? {30'h0000_0000, status_q} :
                   hitMask ? {30'h0000_0000, mask_q} :
                   hitCmp ? {24'h00_0000, cmpFlags_q, CMP_LOW_ONES} :
                   wb_adr_i == ADR_LT6 ? {24'h00_0000, win_q[0].lower} :
                   wb_adr_i == ADR_UT6 ? {24'h00_0000, win_q[0].upper} :
                   wb_adr_i == ADR_LT7 ? {24'h00_0000, win_q[1].lower} :
                   wb_adr_i == ADR_UT7 ? {24'h00_0000, win_q[1].upper} :
                   hitVector ? {30'h0000_0000, vector} :
                   hitData ? {24'h00_0000, memRd} : 32'h0000_0000;
endmodule
`default_nettype wire

// *** test/adc_core_model.sv ***
`default_nettype none
module adc_core_model (
  input wire logic [2:0] muxChannel,
  input wire logic sampleHold,
  output logic [7:0] convResult
);
  timeunit 1ns;
  timeprecision 1ns;
  // every input, selected or not, stays an analog source
  logic [7:0] vals [8];
  // inverse while sampling, so a result taken too early is caught
  assign convResult = sampleHold ? ~vals[muxChannel] : vals[muxChannel];
endmodule
`default_nettype wire

// *** test/adc_autoscan_sequencer_sva.sv ***
`default_nettype none
module adc_autoscan_sequencer_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [2:0] muxChannel,
  input wire logic sampleHold,
  input wire logic convActive,
  input wire logic powerDown,
  input wire logic irq,
  input wire logic [2:0] irqLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [7:0] hold_q;
  logic wrAck;
  assign wrAck = wb_ack_o && wb_we_i;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) hold_q <= 8'h00;
    else hold_q <= sampleHold ? hold_q + 8'h01 : 8'h00;
  property p_samp; $fell(sampleHold) && convActive |-> hold_q == 8'h54; endproperty
  a_samp: assert property (p_samp) else $error("sampling length");
  property p_conv;
    $fell(sampleHold) && convActive |-> ##53 !(sampleHold && convActive)
      ##1 (sampleHold || !convActive);
  endproperty
  a_conv: assert property (p_conv) else $error("convert length");
  property p_incr;
    $rose(sampleHold) && $past(convActive) && $past(muxChannel) != 3'h7
      |-> muxChannel == $past(muxChannel) + 3'h1;
  endproperty
  a_incr: assert property (p_incr) else $error("channel step");
  property p_mux; sampleHold && $past(sampleHold) |-> $stable(muxChannel); endproperty
  a_mux: assert property (p_mux) else $error("channel moved");
  property p_pd; powerDown && $past(powerDown) |-> !convActive; endproperty
  a_pd: assert property (p_pd) else $error("active in power down");
  property p_lvl; $changed(irqLevel) |-> $past(wrAck) || $past(wrAck, 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level changed alone");
  property p_irq; $fell(irq) |-> $past(wrAck) || $past(wrAck, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq fell alone");
  property p_ack;
    $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o [*2] ##1 wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  c_scan: cover property ($fell(convActive));
  c_wrap: cover property ($rose(sampleHold) && $past(muxChannel) == 3'h7);
  c_irq: cover property ($rose(irq));
endmodule
bind adc_autoscan_sequencer adc_autoscan_sequencer_sva u_sva (.clk_sys, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .muxChannel, .sampleHold, .convActive,
  .powerDown, .irq, .irqLevel);
`default_nettype wire

// *** test/adc_autoscan_sequencer_tb.sv ***
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %0t %h %h", $time, g, e); end end
module adc_autoscan_sequencer_tb
  import adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, extTrigger, timerTrigger;
  logic sampleHold, convActive, powerDown, irq;
  logic [7:0] wb_adr_i, convResult;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i, wb_dat_o, expV;
  logic [2:0] muxChannel, irqLevel;
  logic [31:0] expQ [$];
  int mismatches = 0;
  int nChecks = 0;
  int i;
  adc_autoscan_sequencer u_adc_autoscan_sequencer (.*);
  adc_core_model u_adc_core_model (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      expV = expQ.pop_front();
      `CHK(wb_dat_o, expV)
    end
  task automatic stopTest();
    if (mismatches == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // idle edge so requests never run back to back
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic waitIdle();
    int n = 0;
    repeat (3) @(posedge clk_sys);
    while (convActive !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 2000) mismatches++;
    repeat (60) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic t);
    extTrigger <= !t;
    timerTrigger <= t;
    repeat (2) @(posedge clk_sys);
    extTrigger <= 1'b0;
    timerTrigger <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic irqIs(input logic e);
    @(posedge clk_sys);
    `CHK(irq, e)
  endtask
  initial begin
    #100us;
    mismatches++;
    stopTest();
  end
  initial begin
    rst_b = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, extTrigger, timerTrigger} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    i = $urandom(32'hfd5d_0448);
    for (i = 0; i < 8; i++) u_adc_core_model.vals[i] = 8'($urandom);
    u_adc_core_model.vals[6] = 8'h40;
    u_adc_core_model.vals[7] = 8'h10;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(ADR_CTRL, 32'h0000_0000);
    rd(ADR_CMP, 32'h0000_000F);
    bus(1'b1, 8'h44, 32'h0000_00FF);
    rd(8'h44, 32'h0000_0000);
    // software value first, so the scan must visibly replace it
    bus(1'b1, 8'h2C, {24'h00_0000, ~u_adc_core_model.vals[3]});
    rd(8'h2C, {24'h00_0000, ~u_adc_core_model.vals[3]});
    bus(1'b1, ADR_LT6, 32'h0000_0040);
    bus(1'b1, ADR_UT6, 32'h0000_0041);
    bus(1'b1, ADR_LT7, 32'h0000_0020);
    bus(1'b1, ADR_MASK, 32'h0000_0003);
    bus(1'b1, ADR_CTRL, 32'h0000_052D);
    waitIdle();
    `CHK(powerDown, 1'b0)
    `CHK(irqLevel, 3'h5)
    rd(ADR_CTRL, 32'h0000_052C);
    for (i = 0; i < 8; i++)
      rd(8'h20 + 8'(4 * i), i < 3 ? 32'h0000_0000 : 32'(u_adc_core_model.vals[i]));
    rd(ADR_STATUS, 32'h0000_0003);
    rd(ADR_CMP, 32'h0000_004F);
    rd(ADR_VECTOR, 32'h0000_0001);
    bus(1'b1, ADR_MASK, 32'h0000_0000);
    irqIs(1'b0);
    bus(1'b1, ADR_MASK, 32'h0000_0001);
    irqIs(1'b1);
    bus(1'b1, ADR_STATUS, 32'h0000_0002);
    rd(ADR_CMP, 32'h0000_000F);
    rd(ADR_VECTOR, 32'h0000_0002);
    bus(1'b1, ADR_STATUS, 32'h0000_0001);
    irqIs(1'b0);
    bus(1'b1, ADR_CTRL, 32'h0000_007A);
    pulse(1'b0);
    repeat (150) @(posedge clk_sys);
    u_adc_core_model.vals[6] <= 8'h5A;
    repeat (300) @(posedge clk_sys);
    rd(8'h38, 32'h0000_005A);
    rd(ADR_CTRL, 32'h0000_007B);
    bus(1'b1, ADR_CTRL, 32'h0000_007A);
    waitIdle();
    // clear both events so only the timer-started scan can set them
    bus(1'b1, ADR_STATUS, 32'h0000_0003);
    bus(1'b1, ADR_CTRL, 32'h0000_00FC);
    pulse(1'b1);
    repeat (60) @(posedge clk_sys);
    pulse(1'b0);
    repeat (100) @(posedge clk_sys);
    `CHK(convActive, 1'b0)
    rd(ADR_CTRL, 32'h0000_00FC);
    rd(ADR_STATUS, 32'h0000_0003);
    bus(1'b1, ADR_CTRL, 32'h0000_002D);
    repeat (20) @(posedge clk_sys);
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    @(posedge clk_sys);
    `CHK(convActive, 1'b0)
    `CHK(powerDown, 1'b1)
    stopTest();
  end
endmodule
`default_nettype wire
